// >>> lpm_mode_checker.sv
// concurrent checks on the mode controller ports
`timescale 1ns/1ps

module lpm_mode_checker (
  // clock and reset
  input wire core_clk,
  input wire rstn,
  // bus read channel
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  // core and mode
  input wire instr_done,
  input wire half_en,
  input wire mc_en,
  input wire osc_stop,
  input wire core_run,
  input wire ram_block,
  input wire func_reg_reset,
  input wire wake_pulse,
  // pin drive
  input wire addr_latch_out,
  input wire addr_latch_oe,
  input wire read_strobe_out,
  input wire read_strobe_oe,
  input wire weak_pullup,
  input wire port0_float
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  // ----------
  // sequences
  // ----------
  sequence s_quiet;
    !addr_latch_out && !read_strobe_out && !core_run;
  endsequence
  sequence s_after_instr;
    $past(instr_done, 2);
  endsequence

  // ----------
  // assertions
  // ----------
  a_half_divide: assert property (half_en |=> !half_en)
    else $error("divide-by-two enable held high");
  a_mc_spacing: assert property (mc_en |=> !mc_en [*8])
    else $error("machine cycle pulses too close");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_pd_quiet: assert property (osc_stop |-> s_quiet)
    else $error("power down pins or core not quiet");
  a_pd_entry: assert property ($rose(osc_stop) |-> s_after_instr)
    else $error("power down began without completed instruction");
  a_window_runs: assert property (ram_block |-> core_run)
    else $error("ram blocked while core halted");
  a_wake_once: assert property (wake_pulse |=> !wake_pulse)
    else $error("wake pulse longer than one cycle");
  a_wake_clear: assert property (wake_pulse |-> !osc_stop)
    else $error("wake with oscillator stopped");
  a_emul_pins: assert property (weak_pullup |->
    port0_float && !addr_latch_oe && !read_strobe_oe)
    else $error("emulation pins driven");
  a_emul_exit: assert property ($fell(weak_pullup) |->
    func_reg_reset || $past(func_reg_reset))
    else $error("emulation left without reset");
endmodule

// >>> lpm_mode_ctrl.v
// low-power, emulation and fetch-strap mode controller with axi4-lite registers
//
// Function
// [R1] strap low fetches external, high internal
// [R2] lock bits set: latch strap at reset
// [R3] internal timing from divide-by-two of oscillator
// [R4] idle stops execution, registers and ram kept
// [R5] idle ends on reset or enabled interrupt
// [R6] option keeps counter array running in idle
// [R7] power down stops oscillator after requesting instruction
// [R8] power down exits by reset or interrupt
// [R9] waker holds signal until oscillator settles
// [R10] level irq low restarts, high completes exit
// [R11] resume after instruction that entered power down
// [R12] idle reset window blocks ram, not ports; ports_hold stays high in the window
// [R13] strobe low through reset release enters emulation
// [R14] emulation floats port0, weak pulls elsewhere
// [R15] only ordinary reset leaves emulation
// [R16] strobe and port states in idle, power down
// [R17] reset pin high two machine cycles resets
// [R18] request acts after instruction; power down wins
`timescale 1ns/1ps
`include "lpm_mode_defs.vh"

module lpm_mode_ctrl (
  // clock and reset
  input  wire        core_clk,
  input  wire        rstn,
  // axi4-lite slave
  input  wire [3:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [3:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // device pins
  input  wire        reset_pin,
  input  wire        external_fetch_strap,
  input  wire        ext_irq_zero,
  input  wire        ext_irq_one,
  input  wire        addr_latch_in,
  input  wire        program_read_strobe_in,
  // core side
  input  wire        instr_done,
  input  wire [15:0] next_pc,
  input  wire        irq_pending,
  input  wire        core_latch_strobe,
  input  wire        core_read_strobe,
  // clock and mode outputs
  output reg         half_en,
  output reg         mc_en,
  output reg         osc_stop,
  output reg         core_run,
  output reg         pca_run,
  output reg         ram_block,
  output reg         func_reg_reset,
  output reg         ext_fetch,
  output reg         wake_pulse,
  output reg  [15:0] resume_pc,
  // pin drive
  output reg         addr_latch_out,
  output reg         addr_latch_oe,
  output reg         read_strobe_out,
  output reg         read_strobe_oe,
  output reg         weak_pullup,
  output reg         port0_float,
  output reg         port2_show_addr,
  output reg         ports_hold
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  wire [5:0] pin_s;

  lpm_sync3 #(
    .WIDTH (6),
    .INIT  (6'h3E)
  ) u_sync (
    .core_clk  (core_clk),
    .rstn      (rstn),
    .pin_in    ({program_read_strobe_in, addr_latch_in, ext_irq_one,
                 ext_irq_zero, external_fetch_strap, reset_pin}),
    .level_out (pin_s)
  );

  wire rst_s   = pin_s[0];
  wire strap_s = pin_s[1];
  wire irq0_s  = pin_s[2];
  wire irq1_s  = pin_s[3];
  wire ale_s   = pin_s[4];
  wire program_read_strobe_s  = pin_s[5];

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg  [2:0]  ctrl_reg;
  reg  [5:0]  cfg_reg;
  reg  [2:0]  state_reg;
  reg  [2:0]  state_next;
  reg  [2:0]  half_cnt_reg;
  reg  [1:0]  rst_mc_reg;
  reg         chip_rst_reg;
  reg         once_reg;
  reg         strap_latched_reg;
  reg         strap_hold_reg;
  reg  [3:0]  awaddr_reg;
  reg         aw_full_reg;
  reg  [31:0] wdata_reg;
  reg  [3:0]  wstrb_reg;
  reg         w_full_reg;

  function addr_hit;
    input [3:0] a;
    begin
      addr_hit = (a == `LPM_OFS_CTRL) || (a == `LPM_OFS_CFG) ||
                 (a == `LPM_OFS_STAT) || (a == `LPM_OFS_RESUME);
    end
  endfunction

  // ----------------------------------------------------------------
  // clock divider and machine cycle
  // ----------------------------------------------------------------
  always @(posedge core_clk) begin
    if (!rstn) begin
      half_en      <= 1'b0;
      mc_en        <= 1'b0;
      half_cnt_reg <= 3'h0;
    end else begin
      half_en <= ~half_en; // [R3]
      mc_en   <= 1'b0;
      if (half_en) begin
        if (half_cnt_reg == `LPM_HALF_PER_MC - 3'h1) begin
          half_cnt_reg <= 3'h0;
          mc_en        <= 1'b1;
        end else begin
          half_cnt_reg <= half_cnt_reg + 3'h1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // reset pin qualification, strap and emulation entry
  // ----------------------------------------------------------------
  always @(posedge core_clk) begin
    if (!rstn) begin
      rst_mc_reg        <= 2'h0;
      chip_rst_reg      <= 1'b1;
      once_reg          <= 1'b0;
      strap_latched_reg <= 1'b0;
      strap_hold_reg    <= 1'b1;
    end else begin
      if (!rst_s) begin
        rst_mc_reg <= 2'h0;
        if (chip_rst_reg) begin
          chip_rst_reg <= 1'b0;
          once_reg     <= ~ale_s & program_read_strobe_s; // [R13]
          strap_hold_reg    <= strap_s; // [R2]
          strap_latched_reg <= |cfg_reg[`LPM_CFG_LOCK_HI:`LPM_CFG_LOCK_LO]; // [R2]
        end
      end else if (mc_en) begin
        if (rst_mc_reg == `LPM_RST_MC - 2'h1) begin
          chip_rst_reg <= 1'b1; // [R17]
          once_reg     <= 1'b0; // [R15]
        end else begin
          rst_mc_reg <= rst_mc_reg + 2'h1;
        end
      end
    end
  end

  always @(posedge core_clk) begin
    if (!rstn) begin
      ext_fetch <= 1'b0;
    end else begin
      ext_fetch <= strap_latched_reg ? ~strap_hold_reg : ~strap_s; // [R1]
    end
  end

  // ----------------------------------------------------------------
  // mode state machine
  // ----------------------------------------------------------------
  wire irq0_wake = cfg_reg[`LPM_CFG_IRQ0_EN] & cfg_reg[`LPM_CFG_IRQ0_LVL];
  wire irq1_wake = cfg_reg[`LPM_CFG_IRQ1_EN] & cfg_reg[`LPM_CFG_IRQ1_LVL];
  wire wake_low  = (irq0_wake & ~irq0_s) | (irq1_wake & ~irq1_s);

  always @* begin
    state_next = state_reg;
    case (state_reg)
      `LPM_ST_RUN: begin
        if (once_reg) begin
          state_next = `LPM_ST_ONCE;
        end else if (instr_done && ctrl_reg[`LPM_CTRL_PD]) begin
          state_next = `LPM_ST_PD; // [R18] [R7]
        end else if (instr_done && ctrl_reg[`LPM_CTRL_IDLE]) begin
          state_next = `LPM_ST_IDLE; // [R18] [R4]
        end
      end
      `LPM_ST_IDLE: begin
        if (rst_s) begin
          state_next = `LPM_ST_IDLE_RST; // [R12]
        end else if (irq_pending) begin
          state_next = `LPM_ST_RUN; // [R5]
        end
      end
      `LPM_ST_IDLE_RST: begin
        if (!rst_s) begin
          state_next = `LPM_ST_IDLE;
        end
      end
      `LPM_ST_PD: begin
        if (wake_low) begin
          state_next = `LPM_ST_PD_WAKE; // [R10]
        end
      end
      `LPM_ST_PD_WAKE: begin
        if (!wake_low) begin
          state_next = `LPM_ST_RUN; // [R10] [R8]
        end
      end
      `LPM_ST_ONCE: begin
        state_next = `LPM_ST_ONCE; // [R15]
      end
      default: begin
        state_next = `LPM_ST_RUN;
      end
    endcase
  end

  always @(posedge core_clk) begin
    if (!rstn) begin
      state_reg  <= `LPM_ST_RUN;
      resume_pc  <= 16'h0000;
      wake_pulse <= 1'b0;
    end else begin
      wake_pulse <= 1'b0;
      if (chip_rst_reg) begin
        state_reg <= `LPM_ST_RUN; // [R5] [R8] [R15]
      end else begin
        state_reg <= state_next;
        if (state_reg == `LPM_ST_RUN && state_next == `LPM_ST_PD) begin
          resume_pc <= next_pc; // [R11]
        end
        if (state_reg == `LPM_ST_PD_WAKE && state_next == `LPM_ST_RUN) begin
          wake_pulse <= 1'b1; // [R11]
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // mode outputs
  // ----------------------------------------------------------------
  wire in_idle = (state_reg == `LPM_ST_IDLE) || (state_reg == `LPM_ST_IDLE_RST);
  wire in_pd   = (state_reg == `LPM_ST_PD);
  wire in_wake = (state_reg == `LPM_ST_PD_WAKE);
  wire in_once = (state_reg == `LPM_ST_ONCE);

  always @(posedge core_clk) begin
    if (!rstn) begin
      osc_stop        <= 1'b0;
      core_run        <= 1'b0;
      pca_run         <= 1'b0;
      ram_block       <= 1'b0;
      func_reg_reset  <= 1'b1;
      addr_latch_out  <= 1'b0;
      addr_latch_oe   <= 1'b0;
      read_strobe_out <= 1'b0;
      read_strobe_oe  <= 1'b0;
      weak_pullup     <= 1'b0;
      port0_float     <= 1'b0;
      port2_show_addr <= 1'b0;
      ports_hold      <= 1'b0;
    end else begin
      osc_stop       <= in_pd; // [R7]
      func_reg_reset <= chip_rst_reg; // [R8]
      core_run       <= ~chip_rst_reg & ~in_pd & ~in_wake & ~in_once &
                        (state_reg != `LPM_ST_IDLE); // [R4] [R10] [R12]
      ram_block      <= ~chip_rst_reg & (state_reg == `LPM_ST_IDLE_RST); // [R12]
      pca_run        <= ~chip_rst_reg & ~in_pd & ~in_wake & ~in_once &
                        (~in_idle | ctrl_reg[`LPM_CTRL_PCA_RUN]); // [R6]
      weak_pullup    <= in_once; // [R14]
      addr_latch_oe  <= ~in_once; // [R14]
      read_strobe_oe <= ~in_once; // [R14]
      if (in_idle) begin
        addr_latch_out  <= 1'b1; // [R16]
        read_strobe_out <= 1'b1; // [R16]
      end else if (in_pd || in_wake) begin
        addr_latch_out  <= 1'b0; // [R16]
        read_strobe_out <= 1'b0; // [R16]
      end else begin
        addr_latch_out  <= core_latch_strobe | chip_rst_reg; // [R13]
        read_strobe_out <= core_read_strobe | chip_rst_reg; // [R13]
      end
      port0_float     <= in_once | (ext_fetch & (in_idle | in_pd)); // [R14] [R16]
      port2_show_addr <= ext_fetch & in_idle; // [R16]
      ports_hold      <= in_idle | in_pd; // [R16]
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite write channel
  // ----------------------------------------------------------------
  assign s_axi_awready = ~aw_full_reg & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_full_reg & ~s_axi_bvalid;

  wire wr_go = aw_full_reg & w_full_reg & ~s_axi_bvalid;
  wire taken = ~chip_rst_reg && state_reg == `LPM_ST_RUN && instr_done;

  always @(posedge core_clk) begin
    if (!rstn) begin
      aw_full_reg  <= 1'b0;
      w_full_reg   <= 1'b0;
      awaddr_reg   <= 4'h0;
      wdata_reg    <= 32'h0000_0000;
      wstrb_reg    <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `LPM_RESP_OKAY;
      ctrl_reg     <= `LPM_CTRL_RST;
      cfg_reg      <= `LPM_CFG_RST;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (taken) begin
        ctrl_reg[`LPM_CTRL_IDLE] <= 1'b0; // [R18]
        ctrl_reg[`LPM_CTRL_PD]   <= 1'b0; // [R18]
      end
      if (chip_rst_reg) begin
        ctrl_reg[`LPM_CTRL_IDLE] <= 1'b0;
        ctrl_reg[`LPM_CTRL_PD]   <= 1'b0;
      end
      if (wr_go) begin
        aw_full_reg  <= 1'b0;
        w_full_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= addr_hit(awaddr_reg) ? `LPM_RESP_OKAY : `LPM_RESP_SLVERR;
        if (wstrb_reg[0]) begin
          if (awaddr_reg == `LPM_OFS_CTRL) begin
            ctrl_reg <= wdata_reg[2:0];
          end
          if (awaddr_reg == `LPM_OFS_CFG) begin
            cfg_reg <= wdata_reg[5:0];
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------
  assign s_axi_arready = ~s_axi_rvalid;

  always @(posedge core_clk) begin
    if (!rstn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `LPM_RESP_OKAY;
    end else begin
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= addr_hit(s_axi_araddr) ? `LPM_RESP_OKAY : `LPM_RESP_SLVERR;
        case (s_axi_araddr)
          `LPM_OFS_CTRL:   s_axi_rdata <= {29'h0, ctrl_reg};
          `LPM_OFS_CFG:    s_axi_rdata <= {26'h0, cfg_reg};
          `LPM_OFS_STAT:   s_axi_rdata <= {25'h0, chip_rst_reg, strap_latched_reg,
                                           once_reg, ext_fetch, state_reg};
          `LPM_OFS_RESUME: s_axi_rdata <= {16'h0, resume_pc};
          default:         s_axi_rdata <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule

// >>> lpm_mode_defs.vh
// register map, field positions, state codes and timing counts of the mode controller
`ifndef LPM_MODE_DEFS_VH
`define LPM_MODE_DEFS_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define LPM_OFS_CTRL      4'h0
`define LPM_OFS_CFG       4'h4
`define LPM_OFS_STAT      4'h8
`define LPM_OFS_RESUME    4'hC

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define LPM_CTRL_IDLE     0
`define LPM_CTRL_PD       1
`define LPM_CTRL_PCA_RUN  2
`define LPM_CFG_LOCK_LO   0
`define LPM_CFG_LOCK_HI   1
`define LPM_CFG_IRQ0_EN   2
`define LPM_CFG_IRQ0_LVL  3
`define LPM_CFG_IRQ1_EN   4
`define LPM_CFG_IRQ1_LVL  5
`define LPM_STAT_EXT      3
`define LPM_STAT_ONCE     4
`define LPM_STAT_LATCHED  5
`define LPM_STAT_CHIPRST  6

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define LPM_CTRL_RST      3'h0
`define LPM_CFG_RST       6'h00

// ----------------------------------------------------------------
// mode states
// ----------------------------------------------------------------
`define LPM_ST_RUN        3'h0
`define LPM_ST_IDLE       3'h1
`define LPM_ST_PD         3'h2
`define LPM_ST_PD_WAKE    3'h3
`define LPM_ST_IDLE_RST   3'h4
`define LPM_ST_ONCE       3'h5

// ----------------------------------------------------------------
// timing counts
// ----------------------------------------------------------------
`define LPM_HALF_PER_MC   3'h6
`define LPM_RST_MC        2'h2

// ----------------------------------------------------------------
// bus answers
// ----------------------------------------------------------------
`define LPM_RESP_OKAY     2'h0
`define LPM_RESP_SLVERR   2'h2

`endif

// >>> lpm_pin_model.sv
// pin-side model: reset source, wake interrupts, strap and emulator
`timescale 1ns/1ps

module lpm_pin_model (
  // clock
  input  wire core_clk,
  // strobe drive from the device
  input  wire addr_latch_out,
  input  wire addr_latch_oe,
  input  wire read_strobe_out,
  input  wire read_strobe_oe,
  // pins toward the device
  output reg  reset_pin,
  output reg  external_fetch_strap,
  output reg  ext_irq_zero,
  output reg  ext_irq_one,
  output wire addr_latch_in,
  output wire program_read_strobe_in
);
  reg emu_drive;

  // emulator overrides strobes, weak pull-ups when released
  assign addr_latch_in = emu_drive ? 1'b0 :
    (addr_latch_oe ? addr_latch_out : 1'b1);
  assign program_read_strobe_in = emu_drive | !read_strobe_oe | read_strobe_out;

  initial begin
    reset_pin = 1'b0;
    external_fetch_strap = 1'b1;
    ext_irq_zero = 1'b1;
    ext_irq_one = 1'b1;
    emu_drive = 1'b0;
  end

  task strap(input v);
    @(posedge core_clk);
    external_fetch_strap <= v;
  endtask

  // wake level held by caller until oscillator settles
  task irq_set(input sel, input v);
    @(posedge core_clk);
    if (sel) ext_irq_one <= v;
    else ext_irq_zero <= v;
  endtask

  // reset held well beyond two machine cycles
  task dev_reset(input emu);
    @(posedge core_clk);
    emu_drive <= emu;
    reset_pin <= 1'b1;
    repeat (40) @(posedge core_clk);
    reset_pin <= 1'b0;
    repeat (12) @(posedge core_clk);
    emu_drive <= 1'b0;
  endtask
endmodule

// >>> lpm_sync3.v
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps

module lpm_sync3 #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
  // clock and reset
  input  wire             core_clk,
  input  wire             rstn,
  // pin side
  input  wire [WIDTH-1:0] pin_in,
  // core side
  output reg  [WIDTH-1:0] level_out
);

  reg [WIDTH-1:0] s1_reg;
  reg [WIDTH-1:0] s2_reg;
  reg [WIDTH-1:0] s3_reg;
  integer i;

  // ----------------------------------------------------------------
  // stages and filter
  // ----------------------------------------------------------------
  always @(posedge core_clk) begin
    if (!rstn) begin
      s1_reg    <= INIT;
      s2_reg    <= INIT;
      s3_reg    <= INIT;
      level_out <= INIT;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      for (i = 0; i < WIDTH; i = i + 1) begin
        if (s2_reg[i] == s3_reg[i]) begin
          level_out[i] <= s3_reg[i];
        end
      end
    end
  end

endmodule

// >>> tb.sv
// self-checking bench of the mode controller
`timescale 1ns/1ps
`include "lpm_mode_defs.vh"

module tb;
  // ----------
  // signals
  // ----------
  logic        core_clk, rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, nostb;
  logic        s_axi_arvalid, s_axi_rready, instr_done, irq_pending;
  logic        core_latch_strobe, core_read_strobe;
  logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, d, w, rn;
  logic [15:0] next_pc, pc;
  logic [1:0]  r;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  wire  [15:0] resume_pc;
  wire         half_en, mc_en, osc_stop, core_run, pca_run, ram_block, func_reg_reset;
  wire         ext_fetch, wake_pulse, addr_latch_out, addr_latch_oe, read_strobe_out;
  wire         read_strobe_oe, weak_pullup, port0_float, port2_show_addr, ports_hold;
  wire         reset_pin, external_fetch_strap, ext_irq_zero, ext_irq_one;
  wire         addr_latch_in, program_read_strobe_in;
  integer      seed = 97, n_fail = 0, samples_checked = 0, i, k;

  lpm_mode_ctrl lpm_mode_ctrl_i (.*);
  lpm_pin_model lpm_pin_model_i (.*);

  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    rn <= $random(seed);
    core_latch_strobe <= rn[0];
    core_read_strobe <= rn[1];
  end

  // ----------
  // tasks
  // ----------
  task close_out;
    if (n_fail == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk_word(input [31:0] got, input [31:0] exp);
    samples_checked = samples_checked + 1;
    if (got !== exp) begin
      n_fail = n_fail + 1;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task chk_bit(input got, input exp);
    chk_word({31'h0, got}, {31'h0, exp});
  endtask
  task bound(input integer n);
    if (n >= 60) begin
      n_fail = n_fail + 1;
      close_out;
    end
  endtask
  task tick(input integer n);
    repeat (n) @(posedge core_clk);
  endtask
  task axw(input [3:0] a, input [31:0] v);
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_wstrb <= {rn[3:1], !nostb};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (i = 0; i < 60 && !(s_axi_bvalid === 1'b1 && s_axi_bready); i = i + 1) begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    bound(i);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task axr(input [3:0] a);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (i = 0; i < 60 && !(s_axi_rvalid === 1'b1 && s_axi_rready); i = i + 1) begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    bound(i);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task req(input [31:0] c);
    axw(`LPM_OFS_CTRL, c);
    pc = rn[31:16];
    @(posedge core_clk);
    next_pc <= pc;
    instr_done <= 1'b1;
    @(posedge core_clk);
    instr_done <= 1'b0;
    tick(4);
  endtask

  // ----------
  // scenarios
  // ----------
  initial begin
    core_clk = 1'b0;
    rn = 32'h0000_0000;
    {rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= 6'h00;
    {instr_done, irq_pending, nostb, core_latch_strobe, core_read_strobe} <= 5'h03;
    {s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata, next_pc} <= 60'h0;
    tick(16);
    rstn <= 1'b1;
    tick(8);
    axr(`LPM_OFS_CTRL);
    chk_word(d, {29'h0, `LPM_CTRL_RST});
    axr(`LPM_OFS_CFG);
    chk_word(d, {26'h0, `LPM_CFG_RST});
    axw(`LPM_OFS_STAT, 32'hFFFFFFFF);
    chk_word({30'h0, r}, {30'h0, `LPM_RESP_OKAY});
    axr(`LPM_OFS_STAT);
    chk_word(d & 32'h7, {29'h0, `LPM_ST_RUN});
    nostb <= 1'b1;
    axw(`LPM_OFS_CTRL, 32'h4);
    nostb <= 1'b0;
    axr(`LPM_OFS_CTRL);
    chk_word(d, {29'h0, `LPM_CTRL_RST});
    axr(4'h2);
    chk_word(d, 32'h0000_0000);
    chk_word({30'h0, r}, {30'h0, `LPM_RESP_SLVERR});
    w = rn & 32'h3C;
    axw(`LPM_OFS_CFG, w);
    for (k = 0; k < 4; k = k + 1) begin
      lpm_pin_model_i.strap(k[0]);
      tick(10);
      chk_bit(ext_fetch, !k[0]);
      req({29'h0, k[1], 2'b01});
      chk_bit(core_run, 1'b0);
      chk_bit(pca_run, k[1]);
      chk_bit(addr_latch_out & read_strobe_out, 1'b1);
      chk_bit(port0_float, !k[0]);
      chk_bit(port2_show_addr, !k[0]);
      chk_bit(ports_hold, 1'b1);
      axr(`LPM_OFS_STAT);
      chk_word(d & 32'h7, {29'h0, `LPM_ST_IDLE});
      irq_pending <= 1'b1;
      for (i = 0; i < 60 && core_run !== 1'b1; i = i + 1) @(posedge core_clk);
      bound(i);
      irq_pending <= 1'b0;
    end
    axr(`LPM_OFS_CFG);
    chk_word(d, w);
    for (k = 0; k < 3; k = k + 1) begin
      axw(`LPM_OFS_CFG, k == 0 ? 32'hC : (k == 1 ? 32'h30 : 32'h0));
      req(k == 0 ? 32'h3 : 32'h2);
      chk_bit(osc_stop, 1'b1);
      chk_bit(ports_hold, 1'b1);
      chk_bit(port0_float, 1'b0);
      chk_word({16'h0, resume_pc}, {16'h0, pc});
      lpm_pin_model_i.irq_set(k[0], 1'b0);
      tick(20);
      chk_bit(osc_stop, k == 2);
      chk_bit(core_run, 1'b0);
      lpm_pin_model_i.irq_set(k[0], 1'b1);
      if (k < 2) begin
        for (i = 0; i < 60 && wake_pulse !== 1'b1; i = i + 1) @(posedge core_clk);
        bound(i);
        tick(2);
        chk_bit(core_run, 1'b1);
        axr(`LPM_OFS_CFG);
        chk_word(d, k == 0 ? 32'hC : 32'h30);
      end else begin
        lpm_pin_model_i.dev_reset(1'b0);
        chk_bit(osc_stop | !core_run, 1'b0);
      end
    end
    req(32'h1);
    fork
      lpm_pin_model_i.dev_reset(1'b0);
      begin
        for (i = 0; i < 60 && ram_block !== 1'b1; i = i + 1) @(posedge core_clk);
        bound(i);
        chk_bit(core_run, 1'b1);
      end
    join
    lpm_pin_model_i.dev_reset(1'b1);
    chk_bit(weak_pullup & port0_float, 1'b1);
    axr(`LPM_OFS_STAT);
    chk_bit(d[`LPM_STAT_ONCE], 1'b1);
    lpm_pin_model_i.dev_reset(1'b0);
    chk_bit(weak_pullup, 1'b0);
    axw(`LPM_OFS_CFG, 32'h3);
    lpm_pin_model_i.strap(1'b1);
    lpm_pin_model_i.dev_reset(1'b0);
    lpm_pin_model_i.strap(1'b0);
    tick(10);
    chk_bit(ext_fetch, 1'b0);
    axr(`LPM_OFS_STAT);
    chk_bit(d[`LPM_STAT_LATCHED], 1'b1);
    close_out;
  end
endmodule

bind lpm_mode_ctrl lpm_mode_checker lpm_mode_checker_i (.core_clk, .rstn, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .instr_done, .half_en, .mc_en, .osc_stop, .core_run,
  .ram_block, .func_reg_reset, .wake_pulse, .addr_latch_out, .addr_latch_oe,
  .read_strobe_out, .read_strobe_oe, .weak_pullup, .port0_float);
